// ===== hdl/bldc_commutation_sequencer.sv
// six-step sensorless commutation sequencer with digital pll
`timescale 1ns/1ps
`default_nettype none
module bldc_commutation_sequencer
  import bldc_seq_pkg::*;
#(
  parameter int ADC_W = 10,
  parameter int CTRL_W = 16,
  parameter int ACC_W = 32,
  parameter int POLES = 4,
  parameter int RPM_MAX = 10000,
  parameter int OFFTIME_CAP_PF = 625,
  parameter int ALIGN_CYCLES = 250000,
  parameter int RAMP_CYCLES = 12500000,
  parameter int STEP_PRESCALE = 250
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // current sense and limit codes from the converter
  input wire logic [ADC_W-1:0] CUR_SENSE_I,
  input wire logic [ADC_W-1:0] CUR_LIMIT_I,
  // divided phase voltages from the converter
  input wire logic [ADC_W-1:0] PHASE_SENSE_A_I,
  input wire logic [ADC_W-1:0] PHASE_SENSE_B_I,
  input wire logic [ADC_W-1:0] PHASE_SENSE_C_I,
  // low-side gate drives, active high
  output logic LOW_DRIVE_PHASE_A_O,
  output logic LOW_DRIVE_PHASE_B_O,
  output logic LOW_DRIVE_PHASE_C_O,
  // high-side gate drives, active low
  output logic HIGH_DRIVE_PHASE_A_N_O,
  output logic HIGH_DRIVE_PHASE_B_N_O,
  output logic HIGH_DRIVE_PHASE_C_N_O,
  // oscillator clock and its control node
  output logic COMMUTATION_CLOCK_OUT_O,
  output logic [CTRL_W-1:0] OSCILLATOR_CONTROL_NODE_O,
  // status
  output logic [1:0] SENSE_SELECT_O,
  output logic [2:0] START_MODE_O,
  output logic CUR_LIMIT_ACTIVE_O
);

  // off time in cycles from the capacitor value
  localparam int OFF_CYCLES =
    cap_to_cycles(OFFTIME_CAP_PF, OFF_SWING_MV, OFF_CHARGE_UA);

  // full-scale phase increment: f_max * 2^ACC_W / f_clk
  localparam longint INC_MAX_L =
    (longint'(POLES) * longint'(RPM_MAX) * (64'h1 << ACC_W)) /
    (longint'(OSC_COEF_DIV) * longint'(CLK_HZ));
  localparam logic [ACC_W-1:0] INC_MAX = ACC_W'(INC_MAX_L);

  // widths of the mode and prescale counters and the phase sum
  localparam int TMR_W = 32;
  localparam int PRE_W = 16;
  localparam int SUM_W = ADC_W + 2;

  // drive pattern {la, lb, lc, ha, hb, hc}, 1 = switch on
  function automatic logic [5:0] drive_of(input comm_state_t st);
    case (st)
      ST_R: drive_of = 6'h15;
      ST_A: drive_of = 6'h0C;
      ST_B: drive_of = 6'h0A;
      ST_C: drive_of = 6'h22;
      ST_D: drive_of = 6'h21;
      ST_E: drive_of = 6'h11;
      ST_F: drive_of = 6'h14;
      default: drive_of = 6'h00;
    endcase
  endfunction : drive_of

  // phase routed to the sampler, the one neither driven high nor low
  function automatic logic [1:0] sense_of(input comm_state_t st);
    case (st)
      ST_A: sense_of = SEL_B;
      ST_B: sense_of = SEL_A;
      ST_C: sense_of = SEL_C;
      ST_D: sense_of = SEL_B;
      ST_E: sense_of = SEL_A;
      ST_F: sense_of = SEL_C;
      default: sense_of = SEL_NONE;
    endcase
  endfunction : sense_of

  // next state in the six-step ring; align leaves to state a
  function automatic comm_state_t step_of(input comm_state_t st);
    case (st)
      ST_R: step_of = ST_A;
      ST_A: step_of = ST_B;
      ST_B: step_of = ST_C;
      ST_C: step_of = ST_D;
      ST_D: step_of = ST_E;
      ST_E: step_of = ST_F;
      ST_F: step_of = ST_A;
      default: step_of = ST_A;
    endcase
  endfunction : step_of

  // first and second synchroniser stages for converter codes
  logic [ADC_W-1:0] cur_m, cur_s;
  logic [ADC_W-1:0] lim_m, lim_s;
  logic [ADC_W-1:0] pha_m, pha_s;
  logic [ADC_W-1:0] phb_m, phb_s;
  logic [ADC_W-1:0] phc_m, phc_s;

  // start-up mode and commutation state
  start_mode_t mode;
  comm_state_t state;
  logic [TMR_W-1:0] mode_tmr; // cycles spent in align or ramp

  // oscillator phase accumulator and control node
  logic [ACC_W-1:0] phase_acc;
  logic [CTRL_W-1:0] ctrl_node;
  logic osc_tick; // one pulse per oscillator period

  // divider for control-node slewing
  logic [PRE_W-1:0] pre_cnt;
  logic step_en;

  // one-shot running flag
  logic off_busy;

  // sampler wires
  wire [ADC_W-1:0] sampled;
  wire [SUM_W-1:0] neutral_x3;
  wire [SUM_W-1:0] sampled_x3;
  wire bemf_above;
  wire falling_state;
  wire pll_up;

  // trip, oscillator and drive wires
  wire [ADC_W+2:0] cur_x5;
  wire trip;
  wire [CTRL_W+ACC_W-1:0] inc_prod;
  wire [ACC_W-1:0] inc;
  wire [ACC_W:0] acc_sum;
  wire [5:0] drv;

  // two flip-flops on every converter code before use
  always_ff @(posedge MCLK_I) begin
    cur_m <= CUR_SENSE_I;
    cur_s <= cur_m;
    lim_m <= CUR_LIMIT_I;
    lim_s <= lim_m;
    pha_m <= PHASE_SENSE_A_I;
    pha_s <= pha_m;
    phb_m <= PHASE_SENSE_B_I;
    phb_s <= phb_m;
    phc_m <= PHASE_SENSE_C_I;
    phc_s <= phc_m;
  end

  // trip when sense exceeds one fifth of the limit
  assign cur_x5 = (ADC_W+3)'(cur_s) * (ADC_W+3)'(TRIP_LIMIT_DIV);
  assign trip = cur_x5 > (ADC_W+3)'(lim_s);

  // off-time one-shot
  offtime_oneshot #(
    .CYCLES(OFF_CYCLES),
    .CNT_W(TMR_W)
  ) u_offtime (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .trig_i(trip),
    .busy_o(off_busy)
  );

  // increment scales linearly with the control node, full scale f_max
  assign inc_prod = (CTRL_W+ACC_W)'(ctrl_node) *
                    (CTRL_W+ACC_W)'(INC_MAX);
  assign inc = inc_prod[CTRL_W +: ACC_W];
  assign acc_sum = {1'b0, phase_acc} + {1'b0, inc};

  // accumulator: one wrap is one sweep of the oscillator
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      phase_acc <= '0;
      osc_tick <= 1'b0;
      COMMUTATION_CLOCK_OUT_O <= 1'b0;
    end else begin
      phase_acc <= acc_sum[ACC_W-1:0];
      osc_tick <= acc_sum[ACC_W];
      // high in the first half sweep, low in the second
      COMMUTATION_CLOCK_OUT_O <= ~acc_sum[ACC_W-1];
    end
  end

  // divider giving one-cycle slew enables
  assign step_en = (pre_cnt == PRE_W'(STEP_PRESCALE - 1));
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || step_en) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  // start-up sequence: align, then ramp, then run
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      mode <= MODE_ALIGN;
      mode_tmr <= '0;
    end else begin
      case (mode)
        MODE_ALIGN: begin
          // hold align until its timer runs out
          if (mode_tmr == TMR_W'(ALIGN_CYCLES - 1)) begin
            mode <= MODE_RAMP;
            mode_tmr <= '0;
          end else begin
            mode_tmr <= mode_tmr + 1'b1;
          end
        end
        MODE_RAMP: begin
          // fixed ramp time, then hand over to the pll
          if (mode_tmr == TMR_W'(RAMP_CYCLES - 1)) begin
            mode <= MODE_RUN;
            mode_tmr <= '0;
          end else begin
            mode_tmr <= mode_tmr + 1'b1;
          end
        end
        MODE_RUN: begin
          // terminal mode until reset
          mode_tmr <= '0;
        end
        default: begin
          mode <= MODE_ALIGN;
          mode_tmr <= '0;
        end
      endcase
    end
  end

  // commutation state: parked in align, stepped by oscillator ticks
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state <= ST_R;
    end else if (mode == MODE_ALIGN) begin
      state <= ST_R;
    end else if (osc_tick) begin
      state <= step_of(state);
    end
  end

  // sampler: pick undriven phase, neutral times three from the sum
  assign sampled = (sense_of(state) == SEL_A) ? pha_s :
                   (sense_of(state) == SEL_B) ? phb_s : phc_s;
  assign neutral_x3 = SUM_W'(pha_s) + SUM_W'(phb_s) +
                      SUM_W'(phc_s);
  assign sampled_x3 = SUM_W'(sampled) * SUM_W'(NEUTRAL_DIV);
  assign bemf_above = sampled_x3 > neutral_x3;
  // floating phase falls in states a, c and e, rises in b, d and f
  assign falling_state = (state == ST_A) || (state == ST_C) ||
                         (state == ST_E);
  assign pll_up = bemf_above ^ falling_state;

  // control node: zero in align, fixed ramp source, then pll
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ctrl_node <= '0;
    end else if (step_en) begin
      case (mode)
        MODE_ALIGN: begin
          // no sweep while aligning
          ctrl_node <= '0;
        end
        MODE_RAMP: begin
          // sampler disabled, only the ramp source charges
          if (ctrl_node != '1) begin
            ctrl_node <= ctrl_node + 1'b1;
          end
        end
        MODE_RUN: begin
          // charge or discharge from the back-emf comparison
          if (sense_of(state) == SEL_NONE) begin
            ctrl_node <= ctrl_node;
          end else if (pll_up && ctrl_node != '1) begin
            ctrl_node <= ctrl_node + 1'b1;
          end else if (!pll_up && ctrl_node != '0) begin
            ctrl_node <= ctrl_node - 1'b1;
          end
        end
        default: begin
          ctrl_node <= '0;
        end
      endcase
    end
  end

  // drive pattern of the present state
  assign drv = drive_of(state);

  // registered gate drives: lows gated by one-shot, highs inverted
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      LOW_DRIVE_PHASE_A_O <= 1'b0;
      LOW_DRIVE_PHASE_B_O <= 1'b0;
      LOW_DRIVE_PHASE_C_O <= 1'b0;
      HIGH_DRIVE_PHASE_A_N_O <= 1'b1;
      HIGH_DRIVE_PHASE_B_N_O <= 1'b1;
      HIGH_DRIVE_PHASE_C_N_O <= 1'b1;
    end else begin
      LOW_DRIVE_PHASE_A_O <= drv[5] & ~off_busy;
      LOW_DRIVE_PHASE_B_O <= drv[4] & ~off_busy;
      LOW_DRIVE_PHASE_C_O <= drv[3] & ~off_busy;
      HIGH_DRIVE_PHASE_A_N_O <= ~drv[2];
      HIGH_DRIVE_PHASE_B_N_O <= ~drv[1];
      HIGH_DRIVE_PHASE_C_N_O <= ~drv[0];
    end
  end

  // registered status outputs
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      OSCILLATOR_CONTROL_NODE_O <= '0;
      SENSE_SELECT_O <= SEL_NONE;
      START_MODE_O <= MODE_ALIGN;
      CUR_LIMIT_ACTIVE_O <= 1'b0;
    end else begin
      OSCILLATOR_CONTROL_NODE_O <= ctrl_node;
      // report none while the sampler is off
      SENSE_SELECT_O <= (mode == MODE_RUN) ? sense_of(state) : SEL_NONE;
      START_MODE_O <= mode;
      CUR_LIMIT_ACTIVE_O <= off_busy;
    end
  end

endmodule : bldc_commutation_sequencer
`default_nettype wire

// ===== hdl/bldc_seq_pkg.sv
// constants, types and timing figures for the commutation sequencer
package bldc_seq_pkg;

  // clock figures
  localparam int CLK_HZ = 125000000;
  localparam int CLK_PERIOD_NS = 8;

  // off-time one-shot: capacitor charged by fixed current over a swing
  localparam int OFF_CHARGE_UA = 50;
  localparam int OFF_SWING_MV = 2400;

  // trip threshold is one fifth of the limit input (0.2)
  localparam int TRIP_LIMIT_DIV = 5;

  // max oscillator frequency coefficient 0.05 = 1/20 per pole per rpm
  localparam int OSC_COEF_DIV = 20;

  // neutral is the sum of three phases over three
  localparam int NEUTRAL_DIV = 3;

  // sense selection codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_C = 2'h3;

  // commutation states, align first
  typedef enum logic [6:0] {
    ST_R = 7'h01,
    ST_A = 7'h02,
    ST_B = 7'h04,
    ST_C = 7'h08,
    ST_D = 7'h10,
    ST_E = 7'h20,
    ST_F = 7'h40
  } comm_state_t;

  // start-up modes
  typedef enum logic [2:0] {
    MODE_ALIGN = 3'h1,
    MODE_RAMP = 3'h2,
    MODE_RUN = 3'h4
  } start_mode_t;

  // capacitor in pF charged by ua across mv gives ns; whole cycles, min 1
  function automatic int cap_to_cycles(input longint cap_pf,
                                       input longint swing_mv,
                                       input longint charge_ua);
    longint t_ns;
    longint cyc;
    t_ns = (cap_pf * swing_mv) / charge_ua;
    cyc = t_ns / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return int'(cyc);
  endfunction : cap_to_cycles

endpackage : bldc_seq_pkg

// ===== hdl/offtime_oneshot.sv
// fixed off-time one-shot, not retriggerable while running
`timescale 1ns/1ps
`default_nettype none
module offtime_oneshot #(
  parameter int CYCLES = 3750,
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // trigger and running flag
  input wire logic trig_i,
  output logic busy_o
);

  // cycles left in the current off period
  logic [CNT_W-1:0] remain;

  // load on trigger when idle, count down to zero while busy
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      remain <= '0;
      busy_o <= 1'b0;
    end else if (!busy_o && trig_i) begin
      remain <= CNT_W'(CYCLES - 1);
      busy_o <= 1'b1;
    end else if (busy_o) begin
      // end the period after exactly CYCLES busy cycles
      if (remain == '0) begin
        busy_o <= 1'b0;
      end else begin
        remain <= remain - 1'b1;
      end
    end
  end

endmodule : offtime_oneshot
`default_nettype wire

// ===== tb/bldc_seq_asserts.sv
// port-level assertions for the commutation sequencer
`timescale 1ns/1ps
`default_nettype none
module bldc_seq_asserts
  import bldc_seq_pkg::*;
#(
  parameter int CTRL_W = 16,
  parameter int ALIGN_CYCLES = 250000,
  parameter int OFFTIME_CAP_PF = 625
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // gate drives
  input wire logic LOW_DRIVE_PHASE_A_O,
  input wire logic LOW_DRIVE_PHASE_B_O,
  input wire logic LOW_DRIVE_PHASE_C_O,
  input wire logic HIGH_DRIVE_PHASE_A_N_O,
  input wire logic HIGH_DRIVE_PHASE_B_N_O,
  input wire logic HIGH_DRIVE_PHASE_C_N_O,
  // status
  input wire logic [CTRL_W-1:0] OSCILLATOR_CONTROL_NODE_O,
  input wire logic [1:0] SENSE_SELECT_O,
  input wire logic [2:0] START_MODE_O,
  input wire logic CUR_LIMIT_ACTIVE_O
);
  localparam int OFF_N =
    OFFTIME_CAP_PF * OFF_SWING_MV / OFF_CHARGE_UA / CLK_PERIOD_NS;
  // drives as on-flags, phase a in the top bit
  wire logic [2:0] lo = {LOW_DRIVE_PHASE_A_O, LOW_DRIVE_PHASE_B_O,
                         LOW_DRIVE_PHASE_C_O};
  wire logic [2:0] hi = ~{HIGH_DRIVE_PHASE_A_N_O, HIGH_DRIVE_PHASE_B_N_O,
                          HIGH_DRIVE_PHASE_C_N_O};
  wire logic lim = CUR_LIMIT_ACTIVE_O;
  // one-hot of the phase that the sampler claims
  wire logic [2:0] sel_oh = (SENSE_SELECT_O == SEL_A) ? 3'h4 :
                            (SENSE_SELECT_O == SEL_B) ? 3'h2 : 3'h1;
  logic [31:0] lim_cnt; // cycles the one-shot has run
  logic [31:0] aln_cnt; // cycles spent in align
  logic left_r; // ring has left the align pattern for good
  // helper counters
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      lim_cnt <= 32'h0;
      aln_cnt <= 32'h0;
      left_r <= 1'b0;
    end else begin
      lim_cnt <= lim ? lim_cnt + 32'h1 : 32'h0;
      aln_cnt <= (START_MODE_O == 3'h1) ? aln_cnt + 32'h1 : aln_cnt;
      // ramp keeps the align pattern until the first oscillator wrap
      if (START_MODE_O != 3'h1 && hi != 3'h5) begin
        left_r <= 1'b1;
      end
    end
  end
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  AST_PATTERN: assert property (
    left_r |->
    $onehot(hi) && (lo & hi) == 3'h0 &&
    ($onehot(lo) || lim || $past(lim))) else $error("bad drive pattern");
  AST_ALIGN: assert property (
    (START_MODE_O == 3'h1 && !$past(SRST_I) && !$past(SRST_I, 2)) |->
    hi == 3'h5 && (lo == 3'h2 || (lo == 3'h0 && (lim || $past(lim)))))
    else $error("bad align pattern");
  AST_SELECT: assert property (
    ($stable({lo, hi}) && SENSE_SELECT_O != SEL_NONE &&
     $stable(SENSE_SELECT_O)) |-> ((~(lo | hi)) & sel_oh) == sel_oh)
    else $error("sampled phase is driven");
  AST_SEL_NONE: assert property (
    (START_MODE_O != 3'h4 && $past(START_MODE_O) != 3'h4) |->
    SENSE_SELECT_O == SEL_NONE) else $error("sampler on outside run");
  AST_MODE_ORDER: assert property (
    !$stable(START_MODE_O) |->
    ($past(START_MODE_O) == 3'h1 && START_MODE_O == 3'h2) ||
    ($past(START_MODE_O) == 3'h2 && START_MODE_O == 3'h4))
    else $error("bad mode order");
  AST_ALIGN_LEN: assert property (
    $rose(START_MODE_O[1]) |->
    aln_cnt >= ALIGN_CYCLES && aln_cnt <= ALIGN_CYCLES + 4)
    else $error("align length wrong");
  AST_RAMP_RISE: assert property (
    (START_MODE_O == 3'h2 && $past(START_MODE_O) == 3'h2) |->
    OSCILLATOR_CONTROL_NODE_O >= $past(OSCILLATOR_CONTROL_NODE_O))
    else $error("control node fell in ramp");
  AST_LIMIT_BLANK: assert property (
    (lim && $past(lim)) |-> lo == 3'h0) else $error("low side on in blank");
  AST_LIMIT_LEN: assert property (
    ($fell(lim) && !$past(SRST_I)) |-> lim_cnt == OFF_N)
    else $error("off time length wrong");
endmodule : bldc_seq_asserts
`default_nettype wire

// ===== tb/bridge_motor_model.sv
// bridge and motor: phase voltages from the gate drives
`timescale 1ns/1ps
`default_nettype none
module bridge_motor_model #(
  parameter int ADC_W = 10,
  parameter int PH_HI = 600
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // motor ahead of commutation when high
  input wire logic lead_i,
  // gate drives, phase a in the top bit
  input wire logic [2:0] low_i,
  input wire logic [2:0] high_n_i,
  // divided phase voltages
  output logic [ADC_W-1:0] phase_a_o,
  output logic [ADC_W-1:0] phase_b_o,
  output logic [ADC_W-1:0] phase_c_o
);
  logic fall; // undriven phase falling in this state
  logic [5:0] last; // last pattern with a low side on
  wire logic [2:0] hi = ~high_n_i;
  wire logic [5:0] pat = {low_i, hi};
  wire logic emf_up = fall ^ lead_i;
  // back-emf on the floating phase, above or below half swing
  wire logic [ADC_W-1:0] emf = emf_up ? ADC_W'(PH_HI * 3 / 4) :
                                        ADC_W'(PH_HI / 4);
  // falling and rising alternate each step, blanking ignored
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fall <= 1'b0;
      last <= 6'h15;
    end else if (low_i != 3'h0 && pat != last) begin
      last <= pat;
      fall <= (pat == 6'h15) ? 1'b0 : ~fall;
    end
  end
  // high side gives the rail, low side ground, else back-emf
  assign phase_a_o = hi[2] ? ADC_W'(PH_HI) : low_i[2] ? '0 : emf;
  assign phase_b_o = hi[1] ? ADC_W'(PH_HI) : low_i[1] ? '0 : emf;
  assign phase_c_o = hi[0] ? ADC_W'(PH_HI) : low_i[0] ? '0 : emf;
endmodule : bridge_motor_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the commutation sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bldc_seq_pkg::*;
  // shortened start-up; default 625 pF gives a 30 us off time
  localparam int OFF_N = 3750;
  // on-flags {la,lb,lc,ha,hb,hc} for states r,a..f
  localparam logic [5:0] PATS [7] = '{6'h15, 6'h0C, 6'h0A, 6'h22,
                                      6'h21, 6'h11, 6'h14};
  logic clk, srst, lead, lim, clk_out, prev_clk;
  logic [9:0] sense, limit, pa, pb, pc;
  wire logic [2:0] lows, hn;
  logic [2:0] mode;
  logic [1:0] sel;
  logic [15:0] node, n0;
  logic [5:0] pat_q [$];
  logic [2:0] mode_q [$];
  int fails, n_compared, seed, lim_v, k, wide, n_trip, n_rise, gap;
  logic [5:0] seen;
  logic [2:0] seen_mode;
  bldc_commutation_sequencer #(.RPM_MAX(2000000), .ALIGN_CYCLES(12000),
    .RAMP_CYCLES(20000), .STEP_PRESCALE(1)) u_bldc_commutation_sequencer (
    .MCLK_I(clk), .SRST_I(srst), .CUR_SENSE_I(sense),
    .CUR_LIMIT_I(limit), .PHASE_SENSE_A_I(pa), .PHASE_SENSE_B_I(pb),
    .PHASE_SENSE_C_I(pc), .LOW_DRIVE_PHASE_A_O(lows[2]),
    .LOW_DRIVE_PHASE_B_O(lows[1]), .LOW_DRIVE_PHASE_C_O(lows[0]),
    .HIGH_DRIVE_PHASE_A_N_O(hn[2]), .HIGH_DRIVE_PHASE_B_N_O(hn[1]),
    .HIGH_DRIVE_PHASE_C_N_O(hn[0]), .COMMUTATION_CLOCK_OUT_O(clk_out),
    .OSCILLATOR_CONTROL_NODE_O(node), .SENSE_SELECT_O(sel),
    .START_MODE_O(mode), .CUR_LIMIT_ACTIVE_O(lim));
  bridge_motor_model u_bridge_motor_model (.clk_i(clk), .srst_i(srst),
    .lead_i(lead), .low_i(lows), .high_n_i(hn), .phase_a_o(pa),
    .phase_b_o(pb), .phase_c_o(pc));
  // verdict and end of run
  task automatic end_of_test;
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  // compare one drive pattern
  task automatic chk_pat(input logic [5:0] e, input logic [5:0] g);
    n_compared++;
    if (e !== g) begin
      fails++;
      $display("Error pattern exp %h got %h", e, g);
    end
  endtask : chk_pat
  // compare one start-up mode
  task automatic chk_mode(input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (e !== g) begin
      fails++;
      $display("Error mode exp %h got %h", e, g);
    end
  endtask : chk_mode
  // compare a count or a flag
  task automatic chk_num(input string nm, input int e, input int g);
    n_compared++;
    if (e !== g) begin
      fails++;
      $display("Error %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_num
  // clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watcher: pops the oldest note on each new result
  initial begin
    seen = 6'h0;
    seen_mode = 3'h1;
    wide = 0;
    n_trip = 0;
    n_rise = 0;
    prev_clk = 1'b0;
    forever @(negedge clk) begin
      // rises of the oscillator clock; the first follows reset
      if (!srst) begin
        if (clk_out === 1'b1 && prev_clk === 1'b0) n_rise++;
        prev_clk = clk_out;
      end
      if (!srst && !lim && {lows, ~hn} !== seen) begin
        seen = {lows, ~hn};
        if (pat_q.size() == 0) chk_pat(6'h0, seen);
        else chk_pat(pat_q.pop_front(), seen);
      end
      if (!srst && mode !== seen_mode) begin
        seen_mode = mode;
        if (mode_q.size() == 0) chk_mode(3'h0, mode);
        else chk_mode(mode_q.pop_front(), mode);
      end
      if (lim === 1'b1) wide++;
      else if (wide != 0) begin
        chk_num("off time", OFF_N, wide);
        wide = 0;
        n_trip++;
      end
    end
  end
  // driver
  initial begin
    seed = 77065;
    fails = 0;
    n_compared = 0;
    srst = 1'b1;
    lead = 1'b1;
    sense = '0;
    limit = '0;
    for (k = 0; k < 200; k++) begin
      pat_q.push_back(PATS[k == 0 ? 0 : (k - 1) % 6 + 1]);
    end
    mode_q.push_back(3'h2);
    mode_q.push_back(3'h4);
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    repeat (20) @(posedge clk);
    // trips in align: equal to the threshold, then one above
    for (k = 0; k < 3; k++) begin
      lim_v = 50 + ($random(seed) & 32'h1FF);
      #1 limit = 10'(lim_v);
      sense = 10'(lim_v / 5);
      repeat (10) @(posedge clk);
      chk_num("trip at limit", 0, int'(lim === 1'b1));
      #1 sense = 10'(lim_v / 5 + 1);
      repeat (20) @(posedge clk);
      #1 sense = '0;
      repeat (OFF_N + 10) @(posedge clk);
    end
    chk_num("trips", 0, wide);
    chk_num("trip count", 3, n_trip);
    // wait for run, bounded
    k = 0;
    while (mode !== 3'h4 && k < 30000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 30000) begin
      fails++;
    end else begin
      // pll: node follows the back-emf against neutral
      repeat (20) @(posedge clk);
      n0 = node;
      repeat (400) @(posedge clk);
      chk_num("node up", 1, int'(node > n0));
      #1 lead = 1'b0;
      repeat (20) @(posedge clk);
      n0 = node;
      repeat (400) @(posedge clk);
      chk_num("node down", 1, int'(node < n0));
    end
    // a full ring and its wrap back to state a must have been seen
    chk_num("wrap seen", 1, int'(pat_q.size() <= 192));
    // one step per clock rise; the newest step may still be in flight
    gap = n_rise - 200 + pat_q.size();
    chk_num("clock rises", 1, int'(gap inside {[0:1]}));
    end_of_test();
  end
endmodule : testbench
bind bldc_commutation_sequencer bldc_seq_asserts #(.CTRL_W(CTRL_W),
  .ALIGN_CYCLES(ALIGN_CYCLES), .OFFTIME_CAP_PF(OFFTIME_CAP_PF))
  u_bldc_seq_asserts (.*);
`default_nettype wire
